// file: hdl/scl_config_latches.v
// Purpose: Serial-loaded configuration latch bank driving the synthesizer controls.
// Assumes: Serial clock, data and strobe are synchronous to i_ref_clk.
// Notes: Lock detect counts reference-divider pulses flagged by the phase detector.
// Notes: Latches clear only on i_resetn; the device itself has no reset pin.
// Notes: Select code 2'h3 words are dropped, so no latch sees a stray load.
// Notes: The test latch is not modelled; the test bit cannot change any output.
// Notes: Every output is a flip-flop; field outputs sit one clock behind the latch contents, o_locked and o_band_clk follow the counters.
`include "scl_regs.vh"
module scl_config_latches (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_resetn,
  // Serial load interface
  input wire i_ser_clk,
  input wire i_ser_data,
  input wire i_load_strobe,
  // Loop status
  input wire i_ref_tick,
  input wire i_phase_ok,
  // Divider settings
  output reg [1:0] o_prescaler_sel,
  output reg [4:0] o_swallow_count,
  output reg [12:0] o_main_count,
  output reg [13:0] o_ref_div,
  output reg [18:0] o_total_div,
  output reg o_output_halve_en,
  output reg o_prescaler_src_halved,
  // Charge pump and detector
  output reg [2:0] o_pump_current,
  output reg o_pump_gain_flag,
  output reg o_pump_tristate,
  output reg o_detector_polarity,
  output reg [1:0] o_antibacklash,
  output reg o_counter_reset,
  // Output stage and monitor
  output reg [1:0] o_out_level,
  output reg [1:0] o_core_level,
  output reg o_rf_out_en,
  output reg [2:0] o_monitor_sel,
  output reg o_locked,
  output reg o_band_clk
);

  ////////////////////////////////////////////////////////////////////
  reg [23:0] shift_r;
  reg ser_clk_d_r;
  reg strobe_d_r;
  reg [23:0] ctrl_r;
  reg [23:0] fb_r;
  reg [23:0] ref_r;
  reg gain_r;
  reg [2:0] lock_cnt_r;
  reg [4:0] band_cnt_r;
  reg band_clk_r;
  wire ser_rise;
  wire strobe_rise;
  wire [1:0] sel;
  wire [2:0] lock_need;
  wire [4:0] band_div;
  wire [5:0] pmod;

  assign ser_rise = i_ser_clk & ~ser_clk_d_r;
  assign strobe_rise = i_load_strobe & ~strobe_d_r;
  assign sel = shift_r[1:0];
  // Five good cycles in fine mode, three otherwise
  assign lock_need = ref_r[`SCL_R_LDP] ? `SCL_LOCK_FINE : `SCL_LOCK_COARSE;
  // Band clock divide ratio: 1, 2, 4 or 8 from the two-bit field
  assign band_div = 5'h01 << ref_r[`SCL_R_BSC_LO +: 2];
  // Prescaler modulus 8, 16 or 32
  assign pmod = (ctrl_r[`SCL_C_PRE_LO +: 2] == 2'h0) ? 6'h08 :
                (ctrl_r[`SCL_C_PRE_LO +: 2] == 2'h1) ? 6'h10 : 6'h20;

  ////////////////////////////////////////////////////////////////////
  // Field slices, named once so the output logic reads plainly
  wire [1:0] pre_f;
  wire [2:0] cpa_f;
  wire [2:0] cpb_f;
  wire [1:0] lvl_f;
  wire mute_f;
  wire tri_f;
  wire pol_f;
  wire [2:0] mon_f;
  wire cnt_rst_f;
  wire [1:0] core_f;
  wire [4:0] a_f;
  wire [12:0] b_f;
  wire halve_f;
  wire psrc_f;
  wire [13:0] r_f;
  wire [1:0] abp_f;

  // Control word fields
  assign pre_f = ctrl_r[`SCL_C_PRE_LO +: 2];
  assign cpa_f = ctrl_r[`SCL_C_CPA_LO +: 3];
  assign cpb_f = ctrl_r[`SCL_C_CPB_LO +: 3];
  assign lvl_f = ctrl_r[`SCL_C_LVL_LO +: 2];
  assign mute_f = ctrl_r[`SCL_C_MUTE];
  assign tri_f = ctrl_r[`SCL_C_TRI];
  assign pol_f = ctrl_r[`SCL_C_POL];
  assign mon_f = ctrl_r[`SCL_C_MON_LO +: 3];
  assign cnt_rst_f = ctrl_r[`SCL_C_CNT_RST];
  assign core_f = ctrl_r[`SCL_C_CORE_LO +: 2];

  // Feedback word fields; the reserved bit is never read
  assign a_f = fb_r[`SCL_F_A_LO +: 5];
  assign b_f = fb_r[`SCL_F_B_LO +: 13];
  assign halve_f = fb_r[`SCL_F_HALVE];
  assign psrc_f = fb_r[`SCL_F_PSRC];

  // Reference word fields
  assign r_f = ref_r[`SCL_R_R_LO +: 14];
  assign abp_f = ref_r[`SCL_R_ABP_LO +: 2];

  ////////////////////////////////////////////////////////////////////
  // Shift in on serial clock rise, MSB first
  always @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      shift_r <= `SCL_WORD_RST;
      ser_clk_d_r <= 1'b0;
      strobe_d_r <= 1'b0;
    end
    else
    begin
      ser_clk_d_r <= i_ser_clk;
      strobe_d_r <= i_load_strobe;
      if (ser_rise)
        shift_r <= {shift_r[22:0], i_ser_data};
    end
  end

  // Strobe rise copies the word into the addressed latch only
  always @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ctrl_r <= `SCL_WORD_RST;
      fb_r <= `SCL_WORD_RST;
      ref_r <= `SCL_WORD_RST;
      gain_r <= 1'b0;
    end
    else if (strobe_rise)
    begin
      case (sel)
        `SCL_SEL_CTRL:
        begin
          ctrl_r <= shift_r;
          gain_r <= shift_r[`SCL_C_GAIN];
        end
        `SCL_SEL_FB:
        begin
          fb_r <= shift_r;
          gain_r <= shift_r[`SCL_F_GAIN];
        end
        `SCL_SEL_REF:
          ref_r <= shift_r;
        default:
          gain_r <= gain_r; // Initialisation word: not held here
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Lock detector counts consecutive good reference cycles
  always @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      lock_cnt_r <= 3'h0;
      o_locked <= 1'b0;
    end
    else if (ctrl_r[`SCL_C_CNT_RST] || strobe_rise)
    begin
      // Any reprogramming restarts the lock search
      lock_cnt_r <= 3'h0;
      o_locked <= 1'b0;
    end
    else if (i_ref_tick)
    begin
      if (!i_phase_ok)
      begin
        lock_cnt_r <= 3'h0;
        o_locked <= 1'b0;
      end
      else if (lock_cnt_r + 3'h1 >= lock_need)
      begin
        lock_cnt_r <= lock_need;
        o_locked <= 1'b1;
      end
      else
        lock_cnt_r <= lock_cnt_r + 3'h1;
    end
  end

  // Band-select clock toggles every band_div reference ticks
  always @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      band_cnt_r <= 5'h00;
      band_clk_r <= 1'b0;
    end
    else if (ctrl_r[`SCL_C_CNT_RST])
    begin
      band_cnt_r <= 5'h00;
      band_clk_r <= 1'b0;
    end
    else if (i_ref_tick)
    begin
      if (band_cnt_r + 5'h01 >= band_div)
      begin
        band_cnt_r <= 5'h00;
        band_clk_r <= ~band_clk_r;
      end
      else
        band_cnt_r <= band_cnt_r + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Next values that need more than a plain field copy
  reg [18:0] total_nxt;
  reg [2:0] pump_nxt;
  reg tristate_nxt;
  reg rf_en_nxt;

  always @*
  begin
    // Width fits 32 x 8191 + 31, so nothing is lost
    total_nxt = {13'h0000, pmod} * {6'h00, b_f} + {14'h0000, a_f};
    pump_nxt = gain_r ? cpb_f : cpa_f;
    // Test latch not modelled, so the test bit cannot float the pump
    tristate_nxt = tri_f;
    // Muted until lock when mute bit set; lock lags one clock
    rf_en_nxt = ~mute_f | o_locked;
  end

  // Divider counts and total division
  always @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_prescaler_sel <= 2'h0;
      o_swallow_count <= 5'h00;
      o_main_count <= 13'h0000;
      o_total_div <= 19'h00000;
    end
    else
    begin
      o_prescaler_sel <= pre_f;
      o_swallow_count <= a_f;
      o_main_count <= b_f;
      o_total_div <= total_nxt;
    end
  end

  // Reference divider and output halving
  always @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_ref_div <= 14'h0000;
      o_output_halve_en <= 1'b0;
      o_prescaler_src_halved <= 1'b0;
    end
    else
    begin
      o_ref_div <= r_f;
      o_output_halve_en <= halve_f;
      o_prescaler_src_halved <= psrc_f;
    end
  end

  // Charge pump current, gain and three-state
  always @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_pump_current <= 3'h0;
      o_pump_gain_flag <= 1'b0;
      o_pump_tristate <= 1'b0;
    end
    else
    begin
      o_pump_current <= pump_nxt;
      o_pump_gain_flag <= gain_r;
      o_pump_tristate <= tristate_nxt;
    end
  end

  // Detector polarity, antibacklash and counter reset
  always @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_detector_polarity <= 1'b0;
      o_antibacklash <= 2'h0;
      o_counter_reset <= 1'b0;
    end
    else
    begin
      o_detector_polarity <= pol_f;
      o_antibacklash <= abp_f;
      o_counter_reset <= cnt_rst_f;
    end
  end

  // Output stage levels and mute
  always @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_out_level <= 2'h0;
      o_core_level <= 2'h0;
      o_rf_out_en <= 1'b0;
    end
    else
    begin
      o_out_level <= lvl_f;
      o_core_level <= core_f;
      o_rf_out_en <= rf_en_nxt;
    end
  end

  // Monitor select and band-select clock
  always @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_monitor_sel <= 3'h0;
      o_band_clk <= 1'b0;
    end
    else
    begin
      o_monitor_sel <= mon_f;
      o_band_clk <= band_clk_r;
    end
  end

endmodule // scl_config_latches

// file: pkg/scl_regs.vh
// Purpose: Bit positions and constants for the synthesizer configuration latches.
// Assumes: 24-bit serial words, MSB first, latch select in bits 1:0.
// Notes: Positions follow the serial word layout of each latch.
// How it works
// - Select bits (1,0) load feedback latch
// - Select bits (0,1) load reference latch
// - Select bits (0,0) load control latch
// - Strobe rise transfers 24 shifted bits
// - Two three-bit pump current fields
// - Two-bit output power level field
// - Mute outputs until lock when set
// - Gain flag picks current setting two
// - Three-state bit floats charge pump
// - Polarity bit one means positive detector
// - Three-bit monitor output select field
// - Counter reset bit holds R, A, B
// - Five-bit swallow counter, 0 to 31
// - Thirteen-bit main counter, 3 to 8191
// - Division equals prescaler times main plus swallow
// - Shared gain flag follows latest write
// - Feedback bit enables output halving
// - Feedback bit feeds halved output to prescaler
// - Fourteen-bit reference divider, 1 to 16383
// - Lock after five or three good cycles
// - Test bit zero ignores factory test latch
// - Band clock divider after reference divider
`ifndef SCL_REGS_VH
`define SCL_REGS_VH
`define SCL_WORD_W 24
`define SCL_SEL_CTRL 2'h0
`define SCL_SEL_REF 2'h1
`define SCL_SEL_FB 2'h2
`define SCL_WORD_RST 24'h000000
// Control latch fields
`define SCL_C_CNT_RST 4
`define SCL_C_MON_LO 5
`define SCL_C_POL 8
`define SCL_C_TRI 9
`define SCL_C_GAIN 10
`define SCL_C_MUTE 11
`define SCL_C_LVL_LO 12
`define SCL_C_CPA_LO 14
`define SCL_C_CPB_LO 17
`define SCL_C_CORE_LO 2
`define SCL_C_PRE_LO 22
// Feedback latch fields
`define SCL_F_A_LO 2
`define SCL_F_B_LO 8
`define SCL_F_GAIN 21
`define SCL_F_HALVE 22
`define SCL_F_PSRC 23
// Reference latch fields
`define SCL_R_R_LO 2
`define SCL_R_ABP_LO 16
`define SCL_R_LDP 18
`define SCL_R_TMB 19
`define SCL_R_BSC_LO 20
// Lock-detect cycle counts
`define SCL_LOCK_FINE 3'h5
`define SCL_LOCK_COARSE 3'h3
`endif

// file: verification/scl_host_model.sv
// Purpose: Host side of the three-wire load path.
// Assumes: One bit per two ref clocks, changed just after a rise.
// Notes: Idle data line shows the inverse of the last bit.
module scl_host_model (
  // Timing reference
  input logic i_ref_clk,
  // Serial load lines
  output logic o_ser_clk,
  output logic o_ser_data,
  output logic o_load_strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    o_ser_clk = 1'b0;
    o_ser_data = 1'b0;
    o_load_strobe = 1'b0;
  end
  // DB23 first; strobe only after the last clock fall
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--)
    begin
      o_ser_data = w[i];
      o_ser_clk = 1'b1;
      @(posedge i_ref_clk) #1;
      o_ser_clk = 1'b0;
      @(posedge i_ref_clk) #1;
    end
    o_ser_data = ~w[0];
    o_load_strobe = 1'b1;
    repeat (2) @(posedge i_ref_clk) #1;
    o_load_strobe = 1'b0;
  endtask
endmodule // scl_host_model

// file: verification/scl_config_latches_sva.sv
// Purpose: Port assertions for the latch bank.
// Assumes: Serial bits taken on sampled clock rises.
// Notes: Shadow words mirror the last loads.
module scl_config_latches_sva (
  input logic i_ref_clk, i_resetn, i_ser_clk, i_ser_data, i_load_strobe,
  input logic i_ref_tick, i_phase_ok,
  input logic [1:0] o_prescaler_sel, o_antibacklash,
  input logic [4:0] o_swallow_count,
  input logic [12:0] o_main_count,
  input logic [13:0] o_ref_div,
  input logic [18:0] o_total_div,
  input logic [2:0] o_pump_current, o_monitor_sel,
  input logic o_pump_gain_flag, o_pump_tristate, o_detector_polarity,
  input logic o_counter_reset, o_rf_out_en, o_locked,
  input logic o_output_halve_en, o_prescaler_src_halved
);
  logic [23:0] sh_r, w_r, c_r;
  logic sc_r, st_r;
  wire ld = i_load_strobe && !st_r;
  // Shadow serial path, cheaper than decoding each field by hand
  always @(posedge i_ref_clk or negedge i_resetn)
    if (!i_resetn)
    begin
      sh_r <= 24'h0;
      w_r <= 24'h0;
      c_r <= 24'h0;
      sc_r <= 1'b0;
      st_r <= 1'b0;
    end
    else
    begin
      sc_r <= i_ser_clk;
      st_r <= i_load_strobe;
      if (i_ser_clk && !sc_r) sh_r <= {sh_r[22:0], i_ser_data};
      if (ld) w_r <= sh_r;
      if (ld && sh_r[1:0] == 2'h0) c_r <= sh_r;
    end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  fb_fields_a: assert property (
    ld && sh_r[1:0] == 2'h2 |-> ##2 o_swallow_count == w_r[6:2] && o_main_count == w_r[20:8]
    && o_pump_gain_flag == w_r[21] && o_output_halve_en == w_r[22]
    && o_prescaler_src_halved == w_r[23]) else $error("feedback fields wrong");
  ref_fields_a: assert property (
    ld && sh_r[1:0] == 2'h1 |-> ##2 o_ref_div == w_r[15:2] && o_antibacklash == w_r[17:16])
    else $error("reference fields wrong");
  ctrl_fields_a: assert property (
    ld && sh_r[1:0] == 2'h0 |-> ##2 o_pump_tristate == w_r[9] && o_detector_polarity == w_r[8]
    && o_monitor_sel == w_r[7:5] && o_counter_reset == w_r[4]) else $error("control fields wrong");
  gain_pick_a: assert property (
    $stable(o_pump_gain_flag) && $stable(c_r) |->
    o_pump_current == (o_pump_gain_flag ? c_r[19:17] : c_r[16:14])) else $error("bad current");
  total_div_a: assert property (
    $stable(o_main_count) && $stable(o_swallow_count) && $stable(o_prescaler_sel) |->
    o_total_div == (o_prescaler_sel == 2'h0 ? 19'h8 : o_prescaler_sel == 2'h1 ? 19'h10 : 19'h20)
    * o_main_count + o_swallow_count) else $error("total division wrong");
  load_unlock_a: assert property (ld |-> ##2 !o_locked)
    else $error("lock kept over a load");
  bad_tick_a: assert property (i_ref_tick && !i_phase_ok |-> ##2 !o_locked)
    else $error("lock kept after bad tick");
  lock_unmute_a: assert property (o_locked |=> o_rf_out_en)
    else $error("outputs muted while locked");
endmodule // scl_config_latches_sva
bind scl_config_latches scl_config_latches_sva scl_config_latches_sva_i (.*);

// file: verification/testbench.sv
// Purpose: Self-checking bench for the latch bank.
// Assumes: Host model loads words; bench drives ticks.
// Notes: Covers three and five tick lock counts.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_ref_clk, i_resetn, i_ref_tick, i_phase_ok, sck, sda, stb;
  int err_total, comparisons, cyc;
  wire [1:0] ab, core, lvl;
  wire bclk;
  wire [2:0] cur, mon;
  wire [4:0] sw;
  wire [12:0] mc;
  wire [13:0] rd;
  wire [18:0] td;
  wire gain, crst, rfen, lck;
  scl_config_latches scl_config_latches_i (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
    .i_ser_clk(sck), .i_ser_data(sda), .i_load_strobe(stb), .i_ref_tick(i_ref_tick),
    .i_phase_ok(i_phase_ok), .o_prescaler_sel(), .o_swallow_count(sw), .o_main_count(mc),
    .o_ref_div(rd), .o_total_div(td), .o_output_halve_en(), .o_prescaler_src_halved(),
    .o_pump_current(cur), .o_pump_gain_flag(gain), .o_pump_tristate(), .o_detector_polarity(),
    .o_antibacklash(ab), .o_counter_reset(crst), .o_out_level(lvl), .o_core_level(core),
    .o_rf_out_en(rfen), .o_monitor_sel(mon), .o_locked(lck), .o_band_clk(bclk));
  scl_host_model scl_host_model_i (.i_ref_clk(i_ref_clk), .o_ser_clk(sck), .o_ser_data(sda),
    .o_load_strobe(stb));
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  // Load a word, then let decoded outputs settle
  task automatic wr(input logic [23:0] w);
    scl_host_model_i.send(w);
    repeat (3) @(posedge i_ref_clk) #1;
  endtask
  task automatic tk(input int n, input logic ok);
    repeat (n)
    begin
      i_ref_tick = 1'b1;
      i_phase_ok = ok;
      @(posedge i_ref_clk) #1;
      i_ref_tick = 1'b0;
      repeat (2) @(posedge i_ref_clk) #1;
    end
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end
  // Run needs about 360 cycles; far margin
  always @(posedge i_ref_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      give_verdict;
    end
  end
  initial
  begin
    i_resetn = 1'b0;
    i_ref_tick = 1'b0;
    i_phase_ok = 1'b0;
    repeat (12) @(posedge i_ref_clk) #1;
    i_resetn = 1'b1;
    @(posedge i_ref_clk) #1;
    wr(24'h02fffd);
    chk("ref_div", 14'h3fff, rd);
    chk("backlash", 2'h2, ab);
    wr(24'h4aebcc);
    chk("current", 3'h3, cur);
    chk("monitor", 3'h6, mon);
    chk("core", 2'h3, core);
    chk("out_level", 2'h2, lvl);
    chk("rf_en", 1'b0, rfen);
    chk("ref_div", 14'h3fff, rd);
    wr(24'he0037e);
    chk("swallow", 5'h1f, sw);
    chk("total", 19'h4f, td);
    chk("current", 3'h5, cur);
    tk(2, 1'b1);
    chk("locked", 1'b0, lck);
    tk(1, 1'b1);
    chk("rf_en", 1'b1, rfen);
    tk(1, 1'b0);
    chk("locked", 1'b0, lck);
    wr(24'h040005);
    tk(4, 1'b1);
    chk("locked", 1'b0, lck);
    tk(1, 1'b1);
    chk("locked", 1'b1, lck);
    chk("band_clk", 1'b1, bclk);
    wr(24'h400010);
    chk("cnt_rst", 1'b1, crst);
    chk("gain", 1'b0, gain);
    wr(24'h1fff02);
    chk("main", 13'h1fff, mc);
    chk("total", 19'h1fff0, td);
    give_verdict;
  end
endmodule // testbench
